// ===== hw/status_pkg.sv
package status_pkg;

   // Event latch bit positions
   localparam int unsigned EV_COMPLETION     = 0;
   localparam int unsigned EV_BUS_CONTROL    = 1;
   localparam int unsigned EV_QUERY_FAULT    = 2;
   localparam int unsigned EV_DEVICE_FAULT   = 3;
   localparam int unsigned EV_EXEC_FAULT     = 4;
   localparam int unsigned EV_COMMAND_FAULT  = 5;
   localparam int unsigned EV_USER_REQUEST   = 6;
   localparam int unsigned EV_POWER_UP       = 7;

   // Status byte bit positions
   localparam int unsigned SB_REPLY_WAITING  = 4;
   localparam int unsigned SB_EVENT_SUMMARY  = 5;
   localparam int unsigned SB_MASTER_SUMMARY = 6;
   localparam int unsigned SB_OPER_SUMMARY   = 7;

   // Values after reset
   localparam logic [7:0] EVENT_LATCH_RESET = 8'h80;
   localparam logic [7:0] MASK_RESET        = 8'h00;

   // Bits that never latch: bus control request and user request
   localparam logic [7:0] EVENT_NEVER_SET   = 8'h42;

   // Status byte bits with a meaning; the rest read as zero
   localparam logic [7:0] STATUS_USED       = 8'hf0;

   // Register access commands
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_CLEAR_STATUS,
      CMD_WRITE_EVENT_MASK,
      CMD_READ_EVENT_MASK,
      CMD_READ_EVENT_LATCH,
      CMD_WRITE_SERVICE_MASK,
      CMD_READ_SERVICE_MASK,
      CMD_READ_STATUS_BYTE
   } cmd_e;

endpackage

// ===== hw/event_latch.sv
`timescale 1ns/1ps
// Eight sticky event flags with read-clear and global clear
module event_latch #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Events and clears
   input  wire logic [WIDTH-1:0] set_pulse,
   input  wire logic             clear,
   // Latched value
   output logic      [WIDTH-1:0] value_q
);

   logic [WIDTH-1:0] value_d;  // Next latched value

   // Each bit sets on its event; a set in the clearing cycle survives
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (set_pulse[i]) begin
            value_d[i] = 1'b1;
         end else if (clear) begin
            value_d[i] = 1'b0;
         end else begin
            value_d[i] = value_q[i];
         end
      end
   end

   // Power-up flag starts set, all others clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         value_q <= status_pkg::EVENT_LATCH_RESET[WIDTH-1:0];
      end else begin
         value_q <= value_d;
      end
   end

endmodule

// ===== hw/status_reporting.sv
`timescale 1ns/1ps
module status_reporting (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Command port from the command parser
   input  wire logic       cmd_valid,
   input  status_pkg::cmd_e cmd_code,
   input  wire logic [7:0] cmd_data,
   // Error and completion conditions, one-cycle pulses
   input  wire logic       exec_fault,
   input  wire logic       device_fault,
   input  wire logic       command_fault,
   input  wire logic       completion_done,
   input  wire logic       new_message_in,
   // Live conditions
   input  wire logic       reply_pending,
   input  wire logic       operation_event_any,
   // Reply port
   output logic            reply_valid_q,
   output logic [7:0]      reply_data_q,
   // Status outputs
   output logic [7:0]      status_byte_q,
   output logic            service_request_q
);

   logic [7:0] event_latch_q;       // Latched event flags
   logic [7:0] event_set;           // Event set pulses
   logic       latch_clear;         // Clear request for the latch
   logic [7:0] event_mask_q;        // Event enable mask
   logic [7:0] event_mask_d;
   logic [7:0] service_mask_q;      // Service request enable mask
   logic [7:0] service_mask_d;
   logic       reply_valid_d;
   logic [7:0] reply_data_d;
   logic [7:0] status_live;         // Combinational status byte
   logic       master_live;         // Combinational master summary
   logic [7:0] status_byte_d;
   logic       service_request_d;
   logic       master_prev_q;       // Master summary one cycle back
   logic       master_prev_d;
   logic       query_fault;         // Unread reply overrun

   // Unread reply met by a further command is a query fault
   always_comb begin
      query_fault = new_message_in && reply_pending;
   end

   // Gather event sources; reserved bits stay zero
   always_comb begin
      event_set                            = 8'h00;
      event_set[status_pkg::EV_EXEC_FAULT]    = exec_fault;
      event_set[status_pkg::EV_DEVICE_FAULT]  = device_fault;
      event_set[status_pkg::EV_QUERY_FAULT]   = query_fault;
      event_set[status_pkg::EV_COMPLETION]    = completion_done;
      event_set[status_pkg::EV_COMMAND_FAULT] = command_fault;
      event_set = event_set & ~status_pkg::EVENT_NEVER_SET;
   end

   // Latch is cleared by the event query or by clear status
   always_comb begin
      latch_clear = cmd_valid && ((cmd_code == status_pkg::CMD_READ_EVENT_LATCH) ||
                                  (cmd_code == status_pkg::CMD_CLEAR_STATUS));
   end

   event_latch #(
      .WIDTH (8)
   ) u_event_latch (
      .clk       (clk),
      .rstn      (rstn),
      .set_pulse (event_set),
      .clear     (latch_clear),
      .value_q   (event_latch_q)
   );

   // Live status byte; summary bits are not latched
   always_comb begin
      status_live = 8'h00;
      status_live[status_pkg::SB_REPLY_WAITING] = reply_pending;
      status_live[status_pkg::SB_EVENT_SUMMARY] = |(event_latch_q & event_mask_q);
      status_live[status_pkg::SB_OPER_SUMMARY]  = operation_event_any;
      master_live = |(status_live & service_mask_q & ~(8'h01 << status_pkg::SB_MASTER_SUMMARY));
      status_live[status_pkg::SB_MASTER_SUMMARY] = master_live;
      status_live = status_live & status_pkg::STATUS_USED;
   end

   // Status byte and service request; status byte reads never disturb them, an event latch read clears the event summary
   always_comb begin
      status_byte_d     = status_live;
      master_prev_d     = master_live;
      service_request_d = master_live && !master_prev_q;
   end

   // Mask writes and clear status
   always_comb begin
      event_mask_d   = event_mask_q;
      service_mask_d = service_mask_q;
      if (cmd_valid && cmd_code == status_pkg::CMD_WRITE_EVENT_MASK) begin
         event_mask_d = cmd_data;
      end else if (cmd_valid && cmd_code == status_pkg::CMD_WRITE_SERVICE_MASK) begin
         service_mask_d = cmd_data;
      end else if (cmd_valid && cmd_code == status_pkg::CMD_CLEAR_STATUS) begin
         event_mask_d   = status_pkg::MASK_RESET;
         service_mask_d = status_pkg::MASK_RESET;
      end
   end

   // Query replies; the event reply is the value before clearing
   always_comb begin
      reply_valid_d = 1'b0;
      reply_data_d  = 8'h00;
      if (cmd_valid && cmd_code == status_pkg::CMD_READ_EVENT_LATCH) begin
         reply_valid_d = 1'b1;
         reply_data_d  = event_latch_q;
      end else if (cmd_valid && cmd_code == status_pkg::CMD_READ_EVENT_MASK) begin
         reply_valid_d = 1'b1;
         reply_data_d  = event_mask_q;
      end else if (cmd_valid && cmd_code == status_pkg::CMD_READ_SERVICE_MASK) begin
         reply_valid_d = 1'b1;
         reply_data_d  = service_mask_q;
      end else if (cmd_valid && cmd_code == status_pkg::CMD_READ_STATUS_BYTE) begin
         reply_valid_d = 1'b1;
         reply_data_d  = status_live;
      end
   end

   // Register all state; outputs come straight from flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         event_mask_q      <= status_pkg::MASK_RESET;
         service_mask_q    <= status_pkg::MASK_RESET;
         reply_valid_q     <= 1'b0;
         reply_data_q      <= 8'h00;
         status_byte_q     <= 8'h00;
         service_request_q <= 1'b0;
         master_prev_q     <= 1'b0;
      end else begin
         event_mask_q      <= event_mask_d;
         service_mask_q    <= service_mask_d;
         reply_valid_q     <= reply_valid_d;
         reply_data_q      <= reply_data_d;
         status_byte_q     <= status_byte_d;
         service_request_q <= service_request_d;
         master_prev_q     <= master_prev_d;
      end
   end

   // Assertions
   property p_exec_sets;
      @(posedge clk) disable iff (!rstn)
      exec_fault |=> event_latch_q[status_pkg::EV_EXEC_FAULT];
   endproperty
   a_exec_sets: assert property (p_exec_sets) else $error("exec fault not latched");

   property p_dev_sets;
      @(posedge clk) disable iff (!rstn)
      device_fault |=> event_latch_q[status_pkg::EV_DEVICE_FAULT];
   endproperty
   a_dev_sets: assert property (p_dev_sets) else $error("device fault not latched");

   property p_query_sets;
      @(posedge clk) disable iff (!rstn)
      (new_message_in && reply_pending) |=> event_latch_q[status_pkg::EV_QUERY_FAULT];
   endproperty
   a_query_sets: assert property (p_query_sets) else $error("query fault not latched");

   property p_bus_ctrl_zero;
      @(posedge clk) disable iff (!rstn)
      !event_latch_q[status_pkg::EV_BUS_CONTROL];
   endproperty
   a_bus_ctrl_zero: assert property (p_bus_ctrl_zero) else $error("bus control bit set");

   property p_completion_sets;
      @(posedge clk) disable iff (!rstn)
      completion_done |=> event_latch_q[status_pkg::EV_COMPLETION];
   endproperty
   a_completion_sets: assert property (p_completion_sets) else $error("completion not latched");

   sequence s_event_query;
      cmd_valid && cmd_code == status_pkg::CMD_READ_EVENT_LATCH && event_set == 8'h00;
   endsequence
   property p_query_clears;
      @(posedge clk) disable iff (!rstn)
      s_event_query |=> (event_latch_q == 8'h00) && reply_valid_q && (reply_data_q == $past(event_latch_q));
   endproperty
   a_query_clears: assert property (p_query_clears) else $error("event query wrong");

   property p_sticky;
      @(posedge clk) disable iff (!rstn)
      (!latch_clear) |=> ((event_latch_q & $past(event_latch_q)) == $past(event_latch_q));
   endproperty
   a_sticky: assert property (p_sticky) else $error("event bit dropped");

   property p_summary;
      @(posedge clk) disable iff (!rstn)
      ##1 status_byte_q[status_pkg::SB_EVENT_SUMMARY] == $past(|(event_latch_q & event_mask_q));
   endproperty
   a_summary: assert property (p_summary) else $error("event summary wrong");

   property p_unused_zero;
      @(posedge clk) disable iff (!rstn)
      status_byte_q[3:0] == 4'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused status bits set");

   property p_oper;
      @(posedge clk) disable iff (!rstn)
      ##1 status_byte_q[status_pkg::SB_OPER_SUMMARY] == $past(operation_event_any);
   endproperty
   a_oper: assert property (p_oper) else $error("operation summary wrong");

   property p_srq;
      @(posedge clk) disable iff (!rstn)
      $rose(status_byte_q[status_pkg::SB_MASTER_SUMMARY]) |-> service_request_q;
   endproperty
   a_srq: assert property (p_srq) else $error("service request missing");

endmodule

// ===== tb/controller_model.sv
`timescale 1ns/1ps
// Remote controller: one command at a time, driven on the falling edge
module controller_model (
   // Clock
   input  wire logic        clk,
   // Reply from the device
   input  wire logic        reply_valid_q,
   input  wire logic [7:0]  reply_data_q,
   // Command to the device
   output status_pkg::cmd_e cmd_code,
   output logic             cmd_valid,
   output logic [7:0]       cmd_data
);
   // Idle values at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = status_pkg::CMD_NONE;
      cmd_data  = 8'h5a;
   end

   // Issue a command, then wait a bounded time for a reply
   task automatic issue(input status_pkg::cmd_e code, input logic [7:0] data,
                        output logic [7:0] got, output logic seen);
      seen = 1'b0;
      got  = 8'h00;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code  = code;
      cmd_data  = data; // Masks go as whole bytes
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code  = status_pkg::CMD_NONE;
      // Released data shows its inverse so stale data never looks valid
      cmd_data  = ~data;
      for (int n = 0; n < 4; n++) begin
         if (reply_valid_q === 1'b1) begin
            got  = reply_data_q;
            seen = 1'b1;
            break;
         end
         @(negedge clk);
      end
   endtask
endmodule

// ===== tb/status_reporting_test.sv
`timescale 1ns/1ps
// Self-checking bench for the status reporting block
module status_reporting_test;
   logic             clk;             // 100 MHz clock
   logic             rstn;            // Reset, active low
   logic             cmd_valid;       // Command strobe
   status_pkg::cmd_e cmd_code;        // Command code
   logic [7:0]       cmd_data;        // Mask value
   logic [4:0]       ev;              // Exec, device, command, completion, new message
   logic             reply_pending;   // Reply waiting in output buffer
   logic             operation_event_any; // Operation summary source
   logic             reply_valid_q;   // Reply strobe
   logic [7:0]       reply_data_q;    // Reply byte
   logic [7:0]       status_byte_q;   // Live status byte
   logic             service_request_q; // Service request pulse
   int               num_errors;      // Mismatches
   int               samples_checked; // Comparisons
   int               srq_count = 0;   // Service request pulses seen, one writer only
   logic [7:0]       single [4] = '{8'h10, 8'h08, 8'h20, 8'h01}; // Bit per source

   status_reporting u_status_reporting (
      .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .exec_fault(ev[0]), .device_fault(ev[1]), .command_fault(ev[2]), .completion_done(ev[3]),
      .new_message_in(ev[4]), .reply_pending(reply_pending), .operation_event_any(operation_event_any),
      .reply_valid_q(reply_valid_q), .reply_data_q(reply_data_q), .status_byte_q(status_byte_q),
      .service_request_q(service_request_q));

   controller_model u_controller_model (
      .clk(clk), .reply_valid_q(reply_valid_q), .reply_data_q(reply_data_q),
      .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_data(cmd_data));

   // Clock generator
   always #5 clk = ~clk;

   // Count service request pulses mid-cycle, where the flop output has settled
   always @(negedge clk) begin
      if (service_request_q === 1'b1) srq_count++;
   end

   // Byte comparison
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Query; a missing reply counts as a mismatch and ends the run
   task automatic query(input status_pkg::cmd_e code, input logic [7:0] exp, input string what);
      logic [7:0] got;
      logic       seen;
      u_controller_model.issue(code, 8'h00, got, seen);
      if (seen !== 1'b1) begin
         num_errors++;
         end_sim();
      end else begin
         check(what, exp, got);
      end
   endtask

   // Write; no reply may come back
   task automatic write(input status_pkg::cmd_e code, input logic [7:0] data);
      logic [7:0] got;
      logic       seen;
      u_controller_model.issue(code, data, got, seen);
      check("write reply", 8'h00, {7'h00, seen});
   endtask

   // One-cycle event pulse, then let the summary settle
   task automatic pulse(input logic [4:0] v);
      @(negedge clk);
      ev = v;
      @(negedge clk);
      ev = 5'h00;
      repeat (3) @(negedge clk);
   endtask

   // Status byte after a settling delay
   task automatic status_is(input int n, input logic [7:0] exp);
      repeat (n) @(negedge clk);
      check("status byte", exp, status_byte_q);
   endtask

   // Verdict
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      ev = 5'h00;
      reply_pending = 1'b0;
      operation_event_any = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      status_is(1, 8'h00);
      query(status_pkg::CMD_READ_EVENT_LATCH, 8'h80, "power up latch");
      query(status_pkg::CMD_READ_EVENT_LATCH, 8'h00, "latch after read");
      $display("test reset done");
      // Each of exec, device, command and completion alone lands on its own bit
      for (int i = 0; i < 4; i++) begin
         pulse(5'h01 << i);
         query(status_pkg::CMD_READ_EVENT_LATCH, single[i], "single event");
      end
      // A new message with no reply waiting is not a query fault
      pulse(5'h10);
      query(status_pkg::CMD_READ_EVENT_LATCH, 8'h00, "message alone");
      // All at once, with an unread reply; bus control bit stays clear
      reply_pending = 1'b1;
      pulse(5'h1f);
      status_is(0, 8'h10);
      reply_pending = 1'b0;
      status_is(2, 8'h00);
      query(status_pkg::CMD_READ_EVENT_LATCH, 8'h3d, "all events");
      $display("test events done");
      // Event summary and master summary
      write(status_pkg::CMD_NONE, 8'h00);
      write(status_pkg::CMD_WRITE_EVENT_MASK, 8'h10);
      query(status_pkg::CMD_READ_EVENT_MASK, 8'h10, "event mask");
      pulse(5'h01);
      status_is(0, 8'h20);
      write(status_pkg::CMD_WRITE_SERVICE_MASK, 8'h20);
      query(status_pkg::CMD_READ_SERVICE_MASK, 8'h20, "service mask");
      status_is(2, 8'h60);
      check("service requests", 8'h01, srq_count[7:0]);
      query(status_pkg::CMD_READ_STATUS_BYTE, 8'h60, "status read");
      query(status_pkg::CMD_READ_STATUS_BYTE, 8'h60, "status reread");
      query(status_pkg::CMD_READ_EVENT_LATCH, 8'h10, "sticky latch");
      status_is(3, 8'h00);
      $display("test summary done");
      // Operation summary through the service mask
      operation_event_any = 1'b1;
      write(status_pkg::CMD_WRITE_SERVICE_MASK, 8'h80);
      status_is(3, 8'hc0);
      check("service requests", 8'h02, srq_count[7:0]);
      operation_event_any = 1'b0;
      status_is(3, 8'h00);
      $display("test operation done");
      // Clear status wipes latch and masks
      pulse(5'h02);
      write(status_pkg::CMD_CLEAR_STATUS, 8'h00);
      query(status_pkg::CMD_READ_EVENT_LATCH, 8'h00, "latch after clear");
      query(status_pkg::CMD_READ_EVENT_MASK, 8'h00, "event mask after clear");
      query(status_pkg::CMD_READ_SERVICE_MASK, 8'h00, "service mask after clear");
      $display("test clear done");
      end_sim();
   end
endmodule
